// ### core/wut_pkg.sv
// Package: register map, field positions and reset values of the wake-up timer
package wut_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CTRL     = 16'hA003;
  localparam logic [15:0] IDX_CNT_LOW  = 16'hA004;
  localparam logic [15:0] IDX_CNT_MID  = 16'hA005;
  localparam logic [15:0] IDX_CNT_HIGH = 16'hA006;
  localparam logic [15:0] IDX_IRQ_STAT = 16'hA008;
  localparam logic [15:0] IDX_IRQ_CLR  = 16'hA009;
  localparam logic [15:0] IDX_IRQ_EN   = 16'hA00A;

  // Control and status field positions
  localparam int CTRL_FLAG_BIT = 7;
  localparam int CTRL_SEL_LSB  = 5;
  localparam int CTRL_MODE_BIT = 4;
  localparam int CTRL_RUN_BIT  = 3;
  localparam int CTRL_IEN_BIT  = 0;

  // Interrupt status bit of the overflow event
  localparam int IRQ_OVF_BIT = 0;

  // Clock source codes
  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_PLL  = 2'h1;
  localparam logic [1:0] SRC_RTC  = 2'h2;
  localparam logic [1:0] SRC_SLOW = 2'h3;
  localparam int         NUM_SRC  = 4;

  // Reset values and counter limits
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [23:0] COUNT_RESET  = 24'h000000;
  localparam logic [23:0] RELOAD_RESET = 24'h000000;
  localparam logic [23:0] COUNT_MAX    = 24'hFFFFFF;
  localparam logic [7:0]  IRQ_RESET    = 8'h00;

  // AHB transfer type and response codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage

// ### core/wut_timer.sv
// Module: 24-bit wake-up timer with AHB-Lite register slave
//
// Overview of operation
// - One 24-bit up-counter, visible as low, middle and high byte registers.
// - Two-bit select picks fast osc, PLL, RTC or slow osc as count clock.
// - Counting steps on the chosen source's edges, sampled on core_clk; it stops when core_clk stops.
// - Control bit 4 set means auto-reload, clear means free-running.
// - Control bit 3 set lets the counter advance; clear holds it.
// - Overflow sets control bit 7; only a software write of zero clears it.
// - Control bit 0 lets an overflow set interrupt status bit 0, which drives irq if enabled.
// - Count byte writes go to reload in auto-reload, to counter in free-run.
// - Count byte reads return the live counter byte, no snapshot.
// - Count bytes sit low, middle, high at consecutive addresses, reset zero.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
module wut_timer
(
  // System clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Counting clock sources, asynchronous to core_clk
  input  wire logic        fast_internal_oscillator,
  input  wire logic        pll_clk,
  input  wire logic        rtc_clk,
  input  wire logic        slow_internal_oscillator,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Interrupt request, level
  output logic             irq
);

  // Register state
  logic [7:0]  ctrl;
  logic [23:0] count_value;
  logic [23:0] reload;
  logic [7:0]  irq_status;
  logic [7:0]  irq_enable;

  // Clock source synchronisers
  logic [wut_pkg::NUM_SRC-1:0] src_raw;
  logic [wut_pkg::NUM_SRC-1:0] src_meta;
  logic [wut_pkg::NUM_SRC-1:0] src_sync;
  logic [wut_pkg::NUM_SRC-1:0] src_last;
  logic [wut_pkg::NUM_SRC-1:0] src_rise;

  // Bus data phase state
  logic        dp_valid;
  logic        dp_write;
  logic [15:0] dp_idx;

  // Decoded controls and events
  logic        overflow_flag;
  logic [1:0]  clock_source_select;
  logic        reload_mode_bit;
  logic        run_bit;
  logic        overflow_irq_enable;
  logic        tick;
  logic        at_max;
  logic        ovf_evt;
  logic        addr_ok;
  logic        take;
  logic [15:0] a_idx;
  logic        wr_ctrl;
  logic        wr_cnt;
  logic [1:0]  wr_byte;
  logic        wr_irq_clr;
  logic        wr_irq_en;
  logic [7:0]  next_rdata;

  // Control field views
  assign overflow_flag       = ctrl[wut_pkg::CTRL_FLAG_BIT];
  assign clock_source_select = ctrl[wut_pkg::CTRL_SEL_LSB +: 2];
  assign reload_mode_bit     = ctrl[wut_pkg::CTRL_MODE_BIT];
  assign run_bit             = ctrl[wut_pkg::CTRL_RUN_BIT];
  assign overflow_irq_enable = ctrl[wut_pkg::CTRL_IEN_BIT];

  // Source order follows the select codes
  assign src_raw[wut_pkg::SRC_FAST] = fast_internal_oscillator;
  assign src_raw[wut_pkg::SRC_PLL]  = pll_clk;
  assign src_raw[wut_pkg::SRC_RTC]  = rtc_clk;
  assign src_raw[wut_pkg::SRC_SLOW] = slow_internal_oscillator;

  // Each source is synchronised, then its rising edge found on the second stage
  genvar g;
  generate
    for (g = 0; g < wut_pkg::NUM_SRC; g++)
    begin : g_src
      always_ff @(posedge core_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          src_meta[g] <= 1'b0;
          src_sync[g] <= 1'b0;
          src_last[g] <= 1'b0;
        end
        else
        begin
          src_meta[g] <= src_raw[g];
          src_sync[g] <= src_meta[g];
          src_last[g] <= src_sync[g];
        end
      end
      assign src_rise[g] = src_sync[g] & ~src_last[g];
    end
  endgenerate

  // Count on the chosen source's edge; sources must stay below half core_clk
  assign tick    = run_bit & src_rise[clock_source_select];
  assign at_max  = (count_value == wut_pkg::COUNT_MAX);
  assign ovf_evt = tick & at_max;

  // Address phase decode
  assign a_idx   = haddr[17:2];
  assign addr_ok = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
  assign take    = hsel & hready & (htrans == wut_pkg::HTRANS_NONSEQ);

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = wut_pkg::HRESP_OKAY;

  // Capture the address phase for the following data phase
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_idx   <= 16'h0000;
    end
    else if (hready)
    begin
      dp_valid <= take & addr_ok;
      dp_write <= hwrite;
      dp_idx   <= a_idx;
    end
  end

  // Data phase write strobes
  assign wr_ctrl    = dp_valid & dp_write & (dp_idx == wut_pkg::IDX_CTRL);
  assign wr_irq_clr = dp_valid & dp_write & (dp_idx == wut_pkg::IDX_IRQ_CLR);
  assign wr_irq_en  = dp_valid & dp_write & (dp_idx == wut_pkg::IDX_IRQ_EN);
  assign wr_cnt     = dp_valid & dp_write & (dp_idx >= wut_pkg::IDX_CNT_LOW)
                      & (dp_idx <= wut_pkg::IDX_CNT_HIGH);
  assign wr_byte    = dp_idx[1:0] - wut_pkg::IDX_CNT_LOW[1:0];

  // Control register; hardware set of the flag wins over a software clear
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl <= wut_pkg::CTRL_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl[6:3] <= hwdata[6:3];
        ctrl[2:1] <= 2'h0; // Reserved bits read as zero
        ctrl[0]   <= hwdata[0];
      end
      if (ovf_evt)
      begin
        ctrl[wut_pkg::CTRL_FLAG_BIT] <= 1'b1;
      end
      else if (wr_ctrl && !hwdata[wut_pkg::CTRL_FLAG_BIT])
      begin
        ctrl[wut_pkg::CTRL_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // Live counter; a free-run byte write takes that cycle over a tick
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      count_value <= wut_pkg::COUNT_RESET;
    else if (wr_cnt && !reload_mode_bit)
      count_value[wr_byte*8 +: 8] <= hwdata[7:0];
    else if (tick && at_max)
      count_value <= reload_mode_bit ? reload : wut_pkg::COUNT_RESET;
    else if (tick)
      count_value <= count_value + 24'h000001;
  end

  // Reload value, written only in auto-reload mode
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      reload <= wut_pkg::RELOAD_RESET;
    else if (wr_cnt && reload_mode_bit)
      reload[wr_byte*8 +: 8] <= hwdata[7:0];
  end

  // Sticky interrupt status; set wins over clear
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_status <= wut_pkg::IRQ_RESET;
    end
    else
    begin
      if (wr_irq_clr)
      begin
        irq_status <= irq_status & ~hwdata[7:0];
      end
      if (ovf_evt && overflow_irq_enable)
      begin
        irq_status[wut_pkg::IRQ_OVF_BIT] <= 1'b1;
      end
    end
  end

  // Interrupt enable register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_enable <= wut_pkg::IRQ_RESET;
    else if (wr_irq_en)
      irq_enable <= hwdata[7:0];
  end

  // Level interrupt while an enabled status bit stands
  assign irq = |(irq_status & irq_enable);

  // Read mux; count bytes show the live counter at the address phase
  always_comb
  begin
    next_rdata = 8'h00;
    if (addr_ok)
    begin
      unique case (a_idx)
        wut_pkg::IDX_CTRL:     next_rdata = ctrl;
        wut_pkg::IDX_CNT_LOW:  next_rdata = count_value[7:0];
        wut_pkg::IDX_CNT_MID:  next_rdata = count_value[15:8];
        wut_pkg::IDX_CNT_HIGH: next_rdata = count_value[23:16];
        wut_pkg::IDX_IRQ_STAT: next_rdata = irq_status;
        wut_pkg::IDX_IRQ_EN:   next_rdata = irq_enable;
        default:               next_rdata = 8'h00;
      endcase
    end
  end

  // Read data from a flop; no other bytes are latched, so read high byte first
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      hrdata <= 32'h00000000;
    else if (take && !hwrite)
      hrdata <= {24'h000000, next_rdata};
  end

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  property p_wrap;
    tick && at_max && !reload_mode_bit && !wr_cnt |=> count_value == 24'h000000;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("free-run overflow did not wrap to zero");

  property p_reload;
    tick && at_max && reload_mode_bit && !wr_cnt |=> count_value == $past(reload);
  endproperty
  a_reload: assert property (p_reload)
    else $error("auto-reload overflow did not load reload value");

  property p_flag_set;
    ovf_evt |=> overflow_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("overflow did not set flag");

  property p_flag_hold;
    overflow_flag && !(wr_ctrl && !hwdata[7]) |=> overflow_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag cleared without software write");

  property p_stop;
    !run_bit && !wr_cnt |=> $stable(count_value);
  endproperty
  a_stop: assert property (p_stop)
    else $error("counter moved while stopped");

  property p_advance;
    tick && !at_max && !(wr_cnt && !reload_mode_bit)
      |=> count_value == $past(count_value) + 24'h000001;
  endproperty
  a_advance: assert property (p_advance)
    else $error("counter did not advance by one");

  property p_free_write;
    wr_cnt && !reload_mode_bit && dp_idx == wut_pkg::IDX_CNT_LOW
      |=> count_value[7:0] == $past(hwdata[7:0]) && $stable(reload);
  endproperty
  a_free_write: assert property (p_free_write)
    else $error("free-run low byte write not applied to counter");

  property p_byte_write;
    wr_cnt && !reload_mode_bit && dp_idx == wut_pkg::IDX_CNT_HIGH
      |=> count_value[23:16] == $past(hwdata[7:0]) && $stable(reload);
  endproperty
  a_byte_write: assert property (p_byte_write)
    else $error("free-run byte write not applied to counter");

  property p_reload_write;
    wr_cnt && reload_mode_bit && dp_idx == wut_pkg::IDX_CNT_LOW
      |=> reload[7:0] == $past(hwdata[7:0]);
  endproperty
  a_reload_write: assert property (p_reload_write)
    else $error("auto-reload byte write not applied to reload");

  property p_read;
    take && !hwrite && haddr == {14'h0000, wut_pkg::IDX_CNT_MID, 2'h0}
      |=> hrdata[7:0] == $past(count_value[15:8]);
  endproperty
  a_read: assert property (p_read)
    else $error("count read did not return live byte");

  property p_irq;
    ovf_evt && overflow_irq_enable && irq_enable[0] |=> irq ##1 irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled overflow did not raise irq");

endmodule

// ### testbench/wut_timer_tb.sv
// Self-checking bench for the wake-up timer: register slave, counting and interrupt
module wut_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock, reset, counting sources and bus
  logic        core_clk;
  logic        reset_n;
  logic [3:0]  src;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        irq;
  // Observation state
  logic        obs_rd;
  logic        obs_irq;
  logic [31:0] exp_q[$];
  int          errors;
  int          tests_run;
  int          cycles;
  logic [23:0] rld;
  logic [23:0] val;

  wut_timer dut_u (
    .core_clk                 (core_clk),
    .reset_n                  (reset_n),
    .fast_internal_oscillator (src[0]),
    .pll_clk                  (src[1]),
    .rtc_clk                  (src[2]),
    .slow_internal_oscillator (src[3]),
    .hsel                     (hsel),
    .haddr                    (haddr),
    .htrans                   (htrans),
    .hwrite                   (hwrite),
    .hsize                    (hsize),
    .hwdata                   (hwdata),
    .hready                   (hready),
    .hreadyout                (hreadyout),
    .hresp                    (hresp),
    .hrdata                   (hrdata),
    .irq                      (irq)
  );

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  // 25 MHz system clock
  always #20 core_clk = ~core_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Observer: every result that appears is compared with the oldest note
  always @(posedge core_clk)
  begin
    if (obs_rd)
    begin
      check(hrdata, exp_q.pop_front());
      check({31'h0, hresp}, {31'h0, wut_pkg::HRESP_OKAY});
    end
    else if (obs_irq)
      check({31'h0, irq}, exp_q.pop_front());
  end

  // Hang guard; the whole sequence needs well under a tenth of this
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  // One AHB read; data is taken at the edge that ends the data phase
  task automatic rd(input logic [15:0] idx, input logic [7:0] e);
    @(posedge core_clk);
    haddr  <= {14'h0, idx, 2'h0};
    hwrite <= 1'b0;
    htrans <= wut_pkg::HTRANS_NONSEQ;
    exp_q.push_back({24'h0, e});
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    obs_rd <= 1'b1;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    obs_rd <= 1'b0;
  endtask

  // One AHB write of a byte register
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    @(posedge core_clk);
    haddr  <= {14'h0, idx, 2'h0};
    hwrite <= 1'b1;
    htrans <= wut_pkg::HTRANS_NONSEQ;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask

  // High byte first, since the count is not latched across the three reads
  task automatic rdcnt(input logic [23:0] v);
    rd(wut_pkg::IDX_CNT_HIGH, v[23:16]);
    rd(wut_pkg::IDX_CNT_MID, v[15:8]);
    rd(wut_pkg::IDX_CNT_LOW, v[7:0]);
  endtask

  task automatic wcnt(input logic [23:0] v);
    wr(wut_pkg::IDX_CNT_LOW, v[7:0]);
    wr(wut_pkg::IDX_CNT_MID, v[15:8]);
    wr(wut_pkg::IDX_CNT_HIGH, v[23:16]);
  endtask

  task automatic see_irq(input logic e);
    exp_q.push_back({31'h0, e});
    @(posedge core_clk);
    obs_irq <= 1'b1;
    @(posedge core_clk);
    obs_irq <= 1'b0;
  endtask

  // Slow source edges: 3 cycles high, 3 low, so the synchroniser sees each one
  task automatic pulse(input int i, input int n);
    repeat (n)
    begin
      src[i] <= 1'b1;
      repeat (3) @(posedge core_clk);
      src[i] <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask

  // Main sequence
  initial
  begin
    core_clk = 1'b0;
    reset_n  = 1'b0;
    src      = 4'h0;
    hsel     = 1'b1;
    haddr    = 32'h0;
    htrans   = 2'h0;
    hwrite   = 1'b0;
    hsize    = 3'h2;
    hwdata   = 32'h0;
    obs_rd   = 1'b0;
    obs_irq  = 1'b0;
    errors   = 0;
    tests_run = 0;
    cycles   = 0;
    void'($urandom(97154));
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(wut_pkg::IDX_CTRL, 8'h00);
    rdcnt(24'h000000);
    rd(wut_pkg::IDX_IRQ_STAT, 8'h00);
    rd(16'hA007, 8'h00);
    $display("test reset_values done");
    val = 24'($urandom);
    wcnt(val);
    rdcnt(val);
    $display("test free_run_write done");
    // Free-run wrap with the overflow interrupt enabled
    wcnt(24'hFFFFFE);
    wr(wut_pkg::IDX_IRQ_EN, 8'h01);
    wr(wut_pkg::IDX_CTRL, 8'h09);
    pulse(0, 3);
    wr(wut_pkg::IDX_CTRL, 8'h81);
    rd(wut_pkg::IDX_CTRL, 8'h81);
    rdcnt(24'h000001);
    rd(wut_pkg::IDX_IRQ_STAT, 8'h01);
    see_irq(1'b1);
    wr(wut_pkg::IDX_IRQ_EN, 8'h00);
    see_irq(1'b0);
    wr(wut_pkg::IDX_IRQ_CLR, 8'h01);
    wr(wut_pkg::IDX_IRQ_EN, 8'h01);
    see_irq(1'b0);
    rd(wut_pkg::IDX_CTRL, 8'h81);
    wr(wut_pkg::IDX_CTRL, 8'h01);
    rd(wut_pkg::IDX_CTRL, 8'h01);
    $display("test free_run_overflow done");
    // Auto-reload: writes go to the reload store, reads show the live count
    wr(wut_pkg::IDX_CTRL, 8'h00);
    wcnt(24'hFFFFFF);
    rld = 24'($urandom) & 24'h7FFFFF;
    wr(wut_pkg::IDX_CTRL, 8'h10);
    wcnt(rld);
    rdcnt(24'hFFFFFF);
    wr(wut_pkg::IDX_CTRL, 8'h18);
    pulse(0, 2);
    wr(wut_pkg::IDX_CTRL, 8'h90);
    rd(wut_pkg::IDX_CTRL, 8'h90);
    rdcnt(rld + 24'h1);
    rd(wut_pkg::IDX_IRQ_STAT, 8'h00);
    see_irq(1'b0);
    $display("test auto_reload done");
    // Each select code must follow only its own source, and stop must hold
    for (int s = 0; s < 4; s++)
    begin
      wr(wut_pkg::IDX_CTRL, 8'h00);
      wcnt(24'h000000);
      wr(wut_pkg::IDX_CTRL, {1'b0, 2'(s), 5'h08});
      for (int i = 0; i < 4; i++)
        pulse(i, i + 1);
      wr(wut_pkg::IDX_CTRL, {1'b0, 2'(s), 5'h00});
      pulse(s, 2);
      rdcnt(24'(s + 1));
    end
    $display("test clock_select done");
    tally_and_finish();
  end
endmodule
